// ---- rtl/hiccup_pkg.sv ----
// shared constants and carrier types for the overcurrent hiccup sequencer
package hiccup_pkg;
  localparam int hiccup_count_w = 10;                 // counter width for hiccup count
  localparam logic [9:0] hiccup_limit = 10'h200;      // current-limited cycles to hiccup
  localparam int clamp_count_w = 5;                   // width of overcurrent event count
  localparam logic [4:0] clamp_limit = 5'h10;         // events before soft-start clamp
  localparam int clean_count_w = 3;                   // width of clean-cycle count
  localparam logic [2:0] clean_limit = 3'h4;          // clean cycles that clear hiccup count
  localparam int sync_stages = 3;                     // pin synchroniser depth

  // strap decode for one feedback pin
  typedef enum logic [2:0] {
    vout_fixed_5v = 3'h1,
    vout_fixed_3v3 = 3'h2,
    vout_adjustable = 3'h4
  } vout_mode_t;

  // per-channel analog comparator inputs
  typedef struct packed {
    logic switch_clock;    // channel switching-clock level
    logic pwm_request;     // loop asks for high-side on
    logic low_request;     // loop asks for low-side on
    logic over_limit;      // sense above current-limit threshold
    logic min_on_violation;// required on time below minimum
  } chan_sense_t;

  // per-channel drive outputs
  typedef struct packed {
    logic high_side_gate_drive;
    logic low_side_gate_drive;
    logic soft_start_pull_low;
    logic soft_start_clamp;
    logic pulse_skip;
    logic in_hiccup;
  } chan_drive_t;
endpackage

// ---- rtl/hiccup_channel.sv ----
// one buck channel: current limit, clamp counter, hiccup and clean-cycle counters
module hiccup_channel
  import hiccup_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cycle_tick_in,     // one pulse per switching period
  input wire logic over_limit_in,     // synchronised over-limit level
  input wire logic pwm_request_in,
  input wire logic low_request_in,
  input wire logic skip_in,           // min on-time violation
  input wire logic hiccup_enable_in,
  input wire logic restart_in,        // timer threshold restart pulse
  output logic expired_out,           // counter reached, waiting in hiccup
  output hiccup_pkg::chan_drive_t drive_out
);
  logic [hiccup_count_w-1:0] hiccup_count; // current-limited cycles
  logic [clamp_count_w-1:0] event_count;   // overcurrent events for clamp
  logic [clean_count_w-1:0] clean_count;   // consecutive clean cycles
  logic cycle_hit;                         // limit seen in this cycle
  logic in_hiccup;                         // held off until restart

  // note limit hits inside the current switching period
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cycle_tick_in) begin
      cycle_hit <= 1'b0;
    end else if (over_limit_in) begin
      cycle_hit <= 1'b1;
    end
  end

  // hiccup and clean counters advance once per switching period
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hiccup_count <= '0;
      clean_count <= '0;
    end else if (in_hiccup) begin
      hiccup_count <= '0;
      clean_count <= '0;
    end else if (cycle_tick_in) begin
      if (cycle_hit || over_limit_in) begin
        clean_count <= '0;
        if (hiccup_count != hiccup_limit) begin
          hiccup_count <= hiccup_count + 1'b1;
        end
      end else if (clean_count == clean_limit - 3'h1) begin
        clean_count <= '0;
        hiccup_count <= '0;
      end else begin
        clean_count <= clean_count + 1'b1;
      end
    end
  end

  // overcurrent event count arms the soft-start clamp after sixteen
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || in_hiccup) begin
      event_count <= '0;
    end else if (cycle_tick_in && (cycle_hit || over_limit_in) && event_count != clamp_limit) begin
      event_count <= event_count + 1'b1;
    end
  end

  // hiccup state: entered on expiry, left only on the shared restart
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      in_hiccup <= 1'b0;
    end else if (restart_in) begin
      in_hiccup <= 1'b0;
    end else if (hiccup_enable_in && hiccup_count == hiccup_limit) begin
      in_hiccup <= 1'b1;
    end
  end

  // registered drive outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      drive_out <= '0;
    end else begin
      // limit ends the high-side pulse at once; skip drops the pulse
      drive_out.high_side_gate_drive <= pwm_request_in && !over_limit_in && !skip_in && !in_hiccup;
      // fault pull-down of soft-start also kills low side
      drive_out.low_side_gate_drive <= low_request_in && !in_hiccup;
      drive_out.soft_start_pull_low <= in_hiccup;
      drive_out.soft_start_clamp <= (event_count == clamp_limit) && !in_hiccup;
      drive_out.pulse_skip <= skip_in;
      drive_out.in_hiccup <= in_hiccup;
    end
  end
  assign expired_out = in_hiccup;

  chk_hiccup_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (hiccup_enable_in && hiccup_count == hiccup_limit && !restart_in) |=> in_hiccup)
    else $error("hiccup not entered at limit");
  chk_clean_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cycle_tick_in && !in_hiccup && !cycle_hit && !over_limit_in && clean_count == clean_limit - 3'h1)
    |=> hiccup_count == '0)
    else $error("clean cycles did not clear counter");
  chk_limit_cut: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    over_limit_in |=> !drive_out.high_side_gate_drive)
    else $error("high side on during over limit");
  chk_lowside_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    drive_out.soft_start_pull_low |-> !drive_out.low_side_gate_drive)
    else $error("low side on during fault");
  chk_clamp_arm: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    drive_out.soft_start_clamp |-> $past(event_count) == clamp_limit)
    else $error("clamp armed early");
endmodule

// ---- rtl/overcurrent_hiccup_sequencer.sv ----
// two-channel overcurrent hiccup sequencer with strap latching and shared timer pin
module overcurrent_hiccup_sequencer
  import hiccup_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,                 // bias undervoltage lockout, low active
  input wire logic [1:0] strap_at_bias_in,   // feedback strap seen at internal_bias_rail
  input wire logic [1:0] strap_at_ground_in, // feedback strap seen at analog_ground
  input wire logic mode_strap_direct_in,     // mode strap tied straight to ground
  input wire logic timer_pin_at_bias_in,     // hiccup_timer_pin tied high at power-up
  input wire logic timer_threshold_in,       // hiccup_timer_pin reached threshold
  input hiccup_pkg::chan_sense_t sense_ch1_in,
  input hiccup_pkg::chan_sense_t sense_ch2_in,
  output hiccup_pkg::vout_mode_t vout_mode_ch1_out,
  output hiccup_pkg::vout_mode_t vout_mode_ch2_out,
  output logic low_gain_out,                 // ultra-low quiescent gain chosen
  output logic hiccup_disabled_out,
  output logic timer_discharge_out,          // pull hiccup_timer_pin to ground
  output logic timer_charge_out,             // enable timer charge source
  output hiccup_pkg::chan_drive_t drive_ch1_out,
  output hiccup_pkg::chan_drive_t drive_ch2_out
);
  import hiccup_pkg::*;

  localparam int pin_w = 14; // all asynchronous analog inputs but the feedback straps in one bundle

  logic [pin_w-1:0] raw_pins;                 // unsynchronised comparator levels
  logic [pin_w-1:0] sync_a;                   // first stage, read only by sync_b
  logic [pin_w-1:0] sync_b;
  logic [pin_w-1:0] sync_c;
  logic [pin_w-1:0] pins;                     // accepted stable levels
  chan_sense_t s1;
  chan_sense_t s2;
  logic clk1_prev;                            // for switching clock edges
  logic clk2_prev;
  logic tick1;
  logic tick2;
  logic straps_taken;                         // one-shot sample after reset release
  logic expired1;
  logic expired2;
  logic restart;                              // shared restart pulse
  logic next_charging;
  logic charging;
  logic hiccup_off;

  assign raw_pins = {sense_ch2_in, sense_ch1_in, timer_threshold_in, timer_pin_at_bias_in,
                     mode_strap_direct_in, 1'b0};

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
      pins <= '0;
    end else begin
      sync_a <= raw_pins;
      sync_b <= sync_a;
      sync_c <= sync_b;
      for (int i = 0; i < pin_w; i++) begin
        if (sync_b[i] == sync_c[i]) begin
          pins[i] <= sync_c[i];
        end
      end
    end
  end
  assign s1 = pins[8:4];
  assign s2 = pins[13:9];

  // strap pins are static, sampled directly once after release of lockout
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      straps_taken <= 1'b0;
      vout_mode_ch1_out <= vout_fixed_5v;
      vout_mode_ch2_out <= vout_fixed_5v;
      low_gain_out <= 1'b0;
      hiccup_off <= 1'b0;
      hiccup_disabled_out <= 1'b0;
    end else if (!straps_taken) begin
      straps_taken <= 1'b1;
      // rail tie gives 3.3 V, ground tie 5 V, anything else a divider
      vout_mode_ch1_out <= strap_at_bias_in[0] ? vout_fixed_3v3 :
                           strap_at_ground_in[0] ? vout_fixed_5v : vout_adjustable;
      vout_mode_ch2_out <= strap_at_bias_in[1] ? vout_fixed_3v3 :
                           strap_at_ground_in[1] ? vout_fixed_5v : vout_adjustable;
      low_gain_out <= !mode_strap_direct_in;
      hiccup_off <= timer_pin_at_bias_in;
      // reported copy of the latched disable, so the flag stands for the whole power cycle
      hiccup_disabled_out <= timer_pin_at_bias_in;
    end
  end

  // switching-clock rising edges give one tick per period per channel
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clk1_prev <= 1'b0;
      clk2_prev <= 1'b0;
    end else begin
      clk1_prev <= s1.switch_clock;
      clk2_prev <= s2.switch_clock;
    end
  end
  assign tick1 = s1.switch_clock && !clk1_prev;
  assign tick2 = s2.switch_clock && !clk2_prev;

  hiccup_channel u_ch1 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cycle_tick_in(tick1),
    .over_limit_in(s1.over_limit),
    .pwm_request_in(s1.pwm_request),
    .low_request_in(s1.low_request),
    .skip_in(s1.min_on_violation),
    .hiccup_enable_in(straps_taken && !hiccup_off),
    .restart_in(restart),
    .expired_out(expired1),
    .drive_out(drive_ch1_out)
  );

  hiccup_channel u_ch2 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cycle_tick_in(tick2),
    .over_limit_in(s2.over_limit),
    .pwm_request_in(s2.pwm_request),
    .low_request_in(s2.low_request),
    .skip_in(s2.min_on_violation),
    .hiccup_enable_in(straps_taken && !hiccup_off),
    .restart_in(restart),
    .expired_out(expired2),
    .drive_out(drive_ch2_out)
  );

  // a later expiry re-starts the shared charge cycle so both restart together
  always_comb begin
    next_charging = charging;
    if (restart) begin
      next_charging = 1'b0;
    end else if (expired1 || expired2) begin
      next_charging = 1'b1;
    end
  end
  // the later of two expiries restarts charging from ground
  logic late_expiry;
  logic exp1_prev;
  logic exp2_prev;
  assign late_expiry = charging && ((expired1 && !exp1_prev) || (expired2 && !exp2_prev));
  assign restart = charging && !late_expiry && pins[3] && !timer_discharge_out;

  // timer pin control; discharge whenever no charge cycle runs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      charging <= 1'b0;
      exp1_prev <= 1'b0;
      exp2_prev <= 1'b0;
      timer_charge_out <= 1'b0;
      timer_discharge_out <= 1'b1;
    end else begin
      charging <= next_charging;
      exp1_prev <= expired1;
      exp2_prev <= expired2;
      timer_charge_out <= next_charging && !late_expiry;
      timer_discharge_out <= !next_charging || late_expiry;
    end
  end

  chk_idle_discharge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !charging |=> timer_discharge_out || next_charging)
    else $error("timer pin not discharged while idle");
  chk_restart_both: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    restart |=> !expired1 && !expired2)
    else $error("channel held after restart");
  chk_strap_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(straps_taken) |-> $stable(vout_mode_ch1_out) && $stable(low_gain_out))
    else $error("strap setting changed");
  chk_hiccup_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    hiccup_off |-> !expired1 && !expired2)
    else $error("hiccup active while disabled");
endmodule

// ---- sim/power_stage_model.sv ----
// behavioural power stage: switching clocks and hiccup timer capacitor
module power_stage_model #(
  parameter int charge_cycles = 100 // cycles for the capacitor to reach threshold
) (
  input wire logic clk_in,
  input wire logic charge_in,
  input wire logic discharge_in,
  output logic sw_ch1_out,
  output logic sw_ch2_out,
  output logic threshold_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] div = 3'h0; // free-running oscillator divider
  int level = 0; // capacitor voltage in charge steps
  // two switching clocks, half a period apart, free running like the oscillator
  always_ff @(posedge clk_in) begin
    div <= div + 3'h1;
  end
  assign sw_ch1_out = div[2];
  assign sw_ch2_out = ~div[2];
  // capacitor: discharge wins, charge saturates at threshold
  always_ff @(posedge clk_in) begin
    if (discharge_in) begin
      level <= 0;
    end else if (charge_in && level < charge_cycles) begin
      level <= level + 1;
    end
  end
  assign threshold_out = (level >= charge_cycles);
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the overcurrent hiccup sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hiccup_pkg::*;
  logic clk_in, rst_n_in, mode_direct, timer_high, thr, dis, chg, sw1, sw2;
  logic [1:0] at_bias, at_gnd, ol, pwm, lo, mov; // per-channel stimulus, bit 0 is ch1
  chan_sense_t s1, s2;
  vout_mode_t vm1, vm2;
  logic low_gain;
  logic hic_off; // hiccup disabled flag from the block
  chan_drive_t d1, d2;
  int n_errors = 0;
  int samples_checked = 0;
  assign s1 = {sw1, pwm[0], lo[0], ol[0], mov[0]};
  assign s2 = {sw2, pwm[1], lo[1], ol[1], mov[1]};
  overcurrent_hiccup_sequencer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .strap_at_bias_in(at_bias),
    .strap_at_ground_in(at_gnd), .mode_strap_direct_in(mode_direct), .timer_pin_at_bias_in(timer_high),
    .timer_threshold_in(thr), .sense_ch1_in(s1), .sense_ch2_in(s2), .vout_mode_ch1_out(vm1),
    .vout_mode_ch2_out(vm2), .low_gain_out(low_gain), .hiccup_disabled_out(hic_off), .timer_discharge_out(dis),
    .timer_charge_out(chg), .drive_ch1_out(d1), .drive_ch2_out(d2));
  power_stage_model #(.charge_cycles(100)) stage (.clk_in(clk_in), .charge_in(chg), .discharge_in(dis),
    .sw_ch1_out(sw1), .sw_ch2_out(sw2), .threshold_out(thr));
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // one compare, counted, mismatch reported at once
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // switching periods of eight clocks each
  task automatic ticks(input int n);
    repeat (n * 8) @(posedge clk_in);
  endtask
  // bias lockout: straps are set while held, sampled at release
  task automatic power_up(input logic [1:0] b, input logic [1:0] g, input logic m, input logic t);
    rst_n_in <= 1'b0;
    at_bias <= b;
    at_gnd <= g;
    mode_direct <= m;
    timer_high <= t;
    ol <= 2'h0;
    repeat (20) @(posedge clk_in);
    chk(8'(dis), 8'h1);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
  // bounded wait for channel 1 to leave hiccup
  task automatic wait_restart();
    for (int i = 0; i < 400 && d1.in_hiccup !== 1'b0; i++) begin
      @(posedge clk_in);
    end
  endtask
  initial begin
    rst_n_in = 1'b0;
    {at_bias, at_gnd, mode_direct, timer_high} = 6'h0;
    {ol, lo, mov} = 6'h0;
    pwm = 2'h3;
    // strap decode and latch; later strap changes are ignored
    power_up(2'h1, 2'h2, 1'b0, 1'b0);
    chk(8'(vm1), 8'(vout_fixed_3v3));
    chk(8'(vm2), 8'(vout_fixed_5v));
    chk(8'(low_gain), 8'h1);
    chk(8'(chg), 8'h0);
    chk(8'(hic_off), 8'h0);
    at_bias <= 2'h2;
    at_gnd <= 2'h1;
    mode_direct <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk(8'(vm1), 8'(vout_fixed_3v3));
    chk(8'(low_gain), 8'h1);
    power_up(2'h0, 2'h0, 1'b1, 1'b0);
    chk(8'(vm1), 8'(vout_adjustable));
    chk(8'(vm2), 8'(vout_adjustable));
    chk(8'(low_gain), 8'h0);
    // minimum on-time violation on channel 2
    mov <= 2'h2;
    ticks(2);
    chk(8'(d2.pulse_skip), 8'h1);
    chk(8'(d1.pulse_skip), 8'h0);
    chk(8'(d2.high_side_gate_drive), 8'h0);
    mov <= 2'h0;
    ticks(2);
    chk(8'(d2.pulse_skip), 8'h0);
    // current limit, clamp, clean-cycle clear, hiccup on channel 1
    chk(8'(d1.high_side_gate_drive), 8'h1);
    ol <= 2'h1;
    repeat (8) @(posedge clk_in);
    chk(8'(d1.high_side_gate_drive), 8'h0);
    ticks(13);
    chk(8'(d1.soft_start_clamp), 8'h0);
    ticks(4);
    chk(8'(d1.soft_start_clamp), 8'h1);
    ticks(490);
    ol <= 2'h0;
    ticks(5);
    ol <= 2'h1;
    pwm <= 2'h2;
    lo <= 2'h1;
    ticks(508);
    chk(8'(d1.in_hiccup), 8'h0);
    chk(8'(d1.low_side_gate_drive), 8'h1);
    ticks(8);
    chk(8'(d1.in_hiccup), 8'h1);
    chk(8'(d1.soft_start_pull_low), 8'h1);
    chk(8'({d1.high_side_gate_drive, d1.low_side_gate_drive}), 8'h0);
    chk(8'({chg, dis}), 8'h2);
    chk(8'({d2.in_hiccup, d2.high_side_gate_drive}), 8'h1);
    ol <= 2'h0;
    wait_restart();
    chk(8'(d1.in_hiccup), 8'h0);
    repeat (6) @(posedge clk_in);
    chk(8'({d1.soft_start_pull_low, dis}), 8'h1);
    // both channels overloaded, channel 2 expires later
    power_up(2'h0, 2'h3, 1'b1, 1'b0);
    ol <= 2'h1;
    ticks(6);
    ol <= 2'h3;
    ticks(516);
    chk(8'({d1.in_hiccup, d2.in_hiccup}), 8'h3);
    ol <= 2'h0;
    // past the point where the first expiry alone would have restarted; the later one re-armed the charge
    repeat (56) @(posedge clk_in);
    chk(8'({d1.in_hiccup, d2.in_hiccup}), 8'h3);
    wait_restart();
    chk(8'({d1.in_hiccup, d2.in_hiccup}), 8'h0);
    // timer pin tied high at power-up
    power_up(2'h0, 2'h3, 1'b1, 1'b1);
    ol <= 2'h1;
    ticks(530);
    chk(8'({d1.in_hiccup, chg}), 8'h0);
    chk(8'(hic_off), 8'h1);
    end_sim();
  end
  // watchdog, well beyond the full run of about 17000 cycles
  initial begin
    #200us;
    n_errors++;
    end_sim();
  end
endmodule
